// ==== rtl/crs_core_regs.sv ====
// core register set: numbered registers, status views, masks and mode select over apb
`timescale 1ns/1ps

//
// Contract
// - sixteen numbered 32-bit registers, thirteen general
// - narrow accesses reach registers 0 to 7 and 13 to 15, not 8 to 12
// - stack pointer banked between main and process
// - stack pointer low two bits read zero
// - subroutine call stores return address in link
// - program counter bit 0 reads zero
// - status readable jointly or per view
// - application view flags in bits 31..27
// - interrupt view holds exception number 8..0
// - execution view control bits 15..10, 26..25
// - state bit reads one, clearing it faults
// - priority mask passes only nmi and hard fault
// - fault mask passes only nmi
// - base priority blocks equal or higher values
// - mode bit 0 selects user thread level
// - mode bit 1 selects alternate stack
// - handler mode privileged while servicing exception
// - user level special access raises fault
module crs_core_regs #(
   parameter int unsigned BPRI_W = 9 // implemented base priority width
) (
   input wire logic clock_in, // 200 mhz core clock
   input wire logic rst_in, // async, active high
   input wire logic psel_in, // apb select
   input wire logic penable_in, // apb access phase
   input wire logic pwrite_in, // apb direction
   input wire logic [7:0] paddr_in, // apb byte address
   input wire logic [31:0] pwdata_in, // apb write data
   output logic [31:0] prdata_out, // apb read data
   output logic pready_out, // apb ready
   output logic pslverr_out, // apb error
   input wire logic exc_active_in, // core is servicing an exception
   input wire logic [8:0] exc_num_in, // number of that exception
   input wire logic call_in, // subroutine call pulse
   input wire logic [31:0] ret_addr_in, // return address of that call
   input wire logic irq_req_in, // pending request to be checked
   input wire logic [1:0] irq_kind_in, // crs_req_e of that request
   input wire logic [8:0] irq_prio_in, // priority value of that request
   output logic irq_permit_out, // request passes the masks
   output logic fault_out, // one-cycle fault exception pulse
   output logic handler_mode_out, // handler mode
   output logic user_level_out, // unprivileged thread
   output logic [31:0] stack_ptr_out, // active stack pointer, word aligned
   output logic [31:0] pc_out // program counter, half-word aligned
);

   // architectural storage
   logic [31:0] gpr_q [0:crs_pkg::GPR_COUNT-1]; // general registers
   logic [31:0] main_stack_q; // main stack pointer
   logic [31:0] proc_stack_q; // process stack pointer
   logic [31:0] link_q; // return link
   logic [31:0] pc_q; // program counter
   logic [31:0] flags_q; // application and execution view bits
   logic prim_q; // priority mask bit
   logic fltm_q; // fault mask bit
   logic [BPRI_W-1:0] bpri_q; // base priority level
   logic [1:0] mode_q; // operating mode select as stored
   logic narrow_q; // access width control
   logic handler_q; // registered handler mode
   logic [8:0] exc_q; // registered exception number
   // apb answer path and registered outputs
   logic pready_q;
   logic pslverr_q;
   logic [31:0] prdata_q;
   logic fault_q;
   logic permit_q;
   logic user_q;
   logic [31:0] sp_out_q;
   // decode
   crs_pkg::crs_state_s st; // current core state
   logic setup; // apb setup cycle
   logic done; // apb completion edge
   logic acc_err; // request refused
   logic tbit_clr; // write would clear the state bit
   logic [31:0] psr_rd; // combined status value
   logic [31:0] sp_act; // active stack pointer, aligned
   logic [31:0] rd_mux; // read data for the current address
   logic [31:0] wr_sp; // aligned stack write value

   // word aligns a stack value
   function automatic logic [31:0] align_word(input logic [31:0] v);
      align_word = {v[31:2], 2'h0};
   endfunction : align_word

   // offsets that only privileged code may reach
   function automatic logic is_special(input logic [7:0] a);
      is_special = (a >= crs_pkg::OFF_PSR) && (a != crs_pkg::OFF_APP_VIEW) &&
                   (a != crs_pkg::OFF_PSR);
   endfunction : is_special

   // core state decode
   always_comb begin
      st.handler = handler_q;
      st.user = ~handler_q & mode_q[crs_pkg::MODE_PRIV];
      st.alt_stack = ~handler_q & mode_q[crs_pkg::MODE_SPSEL];
      st.narrow = narrow_q;
   end

   // active bank of register 13
   assign sp_act = st.alt_stack ? proc_stack_q : main_stack_q;
   assign wr_sp = align_word(pwdata_in);

   // combined status with the exception number and the state bit forced
   always_comb begin
      psr_rd = flags_q & (crs_pkg::APP_VIEW_MASK | crs_pkg::EXE_VIEW_MASK);
      psr_rd[8:0] = exc_q;
      psr_rd[crs_pkg::EXE_STATE_BIT] = 1'b1;
   end

   assign setup = psel_in & ~penable_in;
   assign done = psel_in & penable_in & pready_q;
   assign tbit_clr = pwrite_in & ~pwdata_in[crs_pkg::EXE_STATE_BIT] &
                     ((paddr_in == crs_pkg::OFF_PSR) || (paddr_in == crs_pkg::OFF_EXE_VIEW));

   // refusal: unmapped, misaligned, narrow high register, user special, state clear
   always_comb begin
      acc_err = 1'b0;
      if ((paddr_in[1:0] != 2'h0) || (paddr_in > crs_pkg::OFF_LAST)) begin
         acc_err = 1'b1; // unmapped
      end else if (st.narrow && (paddr_in < crs_pkg::OFF_SP) &&
                   (paddr_in[5:2] > crs_pkg::LOW_TOP)) begin
         acc_err = 1'b1;
      end else if (st.user && (is_special(paddr_in) ||
                   (pwrite_in && paddr_in == crs_pkg::OFF_PSR))) begin
         acc_err = 1'b1;
      end else if (tbit_clr) begin
         acc_err = 1'b1;
      end
   end

   // read multiplexer
   always_comb begin
      rd_mux = crs_pkg::RST_WORD;
      if (paddr_in < crs_pkg::OFF_SP) begin
         rd_mux = gpr_q[paddr_in[5:2]];
      end else begin
         case (paddr_in)
            crs_pkg::OFF_SP: rd_mux = sp_act;
            crs_pkg::OFF_LINK: rd_mux = link_q;
            crs_pkg::OFF_PC: rd_mux = {pc_q[31:1], 1'b0};
            crs_pkg::OFF_PSR: rd_mux = psr_rd;
            crs_pkg::OFF_APP_VIEW: rd_mux = psr_rd & crs_pkg::APP_VIEW_MASK;
            crs_pkg::OFF_INT_VIEW: rd_mux = psr_rd & crs_pkg::INT_VIEW_MASK;
            crs_pkg::OFF_EXE_VIEW: rd_mux = psr_rd & crs_pkg::EXE_VIEW_MASK;
            crs_pkg::OFF_PRIM: rd_mux = {31'h0, prim_q};
            crs_pkg::OFF_FLTM: rd_mux = {31'h0, fltm_q};
            crs_pkg::OFF_BPRI: rd_mux = 32'(bpri_q);
            crs_pkg::OFF_MODE: rd_mux = {30'h0, st.alt_stack, mode_q[0]};
            crs_pkg::OFF_MAIN_STK: rd_mux = main_stack_q;
            crs_pkg::OFF_PROC_STK: rd_mux = proc_stack_q;
            crs_pkg::OFF_ACC: rd_mux = {31'h0, narrow_q};
            crs_pkg::OFF_STAT: rd_mux = {28'h0, st.narrow, st.alt_stack, st.user, st.handler};
            default: rd_mux = crs_pkg::RST_WORD; // unmapped reads zero
         endcase
      end
   end

   // apb answer: registered in setup, ready in the first access cycle
   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= crs_pkg::RST_WORD;
      end else begin
         pready_q <= setup; // falls again at the completion edge
         if (setup) begin
            pslverr_q <= acc_err;
            prdata_q <= (pwrite_in | acc_err) ? crs_pkg::RST_WORD : rd_mux;
         end
      end
   end

   // fault pulse one cycle after a refused access completes
   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         fault_q <= 1'b0;
      end else begin
         fault_q <= done & pslverr_q;
      end
   end

   // general registers; written only at the completion edge
   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         for (int i = 0; i < crs_pkg::GPR_COUNT; i++) begin
            gpr_q[i] <= crs_pkg::RST_WORD;
         end
      end else if (done && !pslverr_q && pwrite_in && paddr_in < crs_pkg::OFF_SP) begin
         gpr_q[paddr_in[5:2]] <= pwdata_in;
      end
   end

   // banked stack pointers; low bits never stored
   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         main_stack_q <= crs_pkg::RST_WORD;
         proc_stack_q <= crs_pkg::RST_WORD;
      end else if (done && !pslverr_q && pwrite_in) begin
         if ((paddr_in == crs_pkg::OFF_MAIN_STK) ||
             (paddr_in == crs_pkg::OFF_SP && !st.alt_stack)) begin
            main_stack_q <= wr_sp;
         end
         if ((paddr_in == crs_pkg::OFF_PROC_STK) ||
             (paddr_in == crs_pkg::OFF_SP && st.alt_stack)) begin
            proc_stack_q <= wr_sp;
         end
      end
   end

   // return link: a call wins over a software write in the same cycle
   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         link_q <= crs_pkg::RST_WORD;
      end else if (call_in) begin
         link_q <= ret_addr_in;
      end else if (done && !pslverr_q && pwrite_in && paddr_in == crs_pkg::OFF_LINK) begin
         link_q <= pwdata_in;
      end
   end

   // program counter, half-word aligned
   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         pc_q <= crs_pkg::RST_WORD;
      end else if (done && !pslverr_q && pwrite_in && paddr_in == crs_pkg::OFF_PC) begin
         pc_q <= {pwdata_in[31:1], 1'b0};
      end
   end

   // status views; the exception number is never written by software
   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         flags_q <= crs_pkg::RST_FLAGS;
      end else if (done && !pslverr_q && pwrite_in) begin
         case (paddr_in)
            crs_pkg::OFF_PSR: flags_q <= pwdata_in & (crs_pkg::APP_VIEW_MASK |
                                                      crs_pkg::EXE_VIEW_MASK);
            crs_pkg::OFF_APP_VIEW: flags_q <= (flags_q & ~crs_pkg::APP_VIEW_MASK) |
                                              (pwdata_in & crs_pkg::APP_VIEW_MASK);
            crs_pkg::OFF_EXE_VIEW: flags_q <= (flags_q & ~crs_pkg::EXE_VIEW_MASK) |
                                              (pwdata_in & crs_pkg::EXE_VIEW_MASK);
            default: flags_q <= flags_q;
         endcase
      end
   end

   // masks and base priority, cleared by reset
   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         prim_q <= 1'b0;
         fltm_q <= 1'b0;
         bpri_q <= '0;
      end else if (done && !pslverr_q && pwrite_in) begin
         if (paddr_in == crs_pkg::OFF_PRIM) prim_q <= pwdata_in[0];
         if (paddr_in == crs_pkg::OFF_FLTM) fltm_q <= pwdata_in[0];
         if (paddr_in == crs_pkg::OFF_BPRI) bpri_q <= pwdata_in[BPRI_W-1:0];
      end
   end

   // mode select; stack bit stays zero while in handler mode
   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         mode_q <= crs_pkg::RST_MODE;
      end else if (handler_q) begin
         mode_q[crs_pkg::MODE_SPSEL] <= 1'b0;
         if (done && !pslverr_q && pwrite_in && paddr_in == crs_pkg::OFF_MODE) begin
            mode_q[crs_pkg::MODE_PRIV] <= pwdata_in[0];
         end
      end else if (done && !pslverr_q && pwrite_in && paddr_in == crs_pkg::OFF_MODE) begin
         mode_q <= pwdata_in[1:0];
      end
   end

   // access width control and registered exception state
   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         narrow_q <= 1'b0;
         handler_q <= 1'b0;
         exc_q <= '0;
      end else begin
         handler_q <= exc_active_in;
         exc_q <= exc_active_in ? exc_num_in : 9'h000;
         if (done && !pslverr_q && pwrite_in && paddr_in == crs_pkg::OFF_ACC) begin
            narrow_q <= pwdata_in[0];
         end
      end
   end

   // mask check; a zero base priority disables that masking
   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         permit_q <= 1'b0;
      end else begin
         case (crs_pkg::crs_req_e'(irq_kind_in))
            crs_pkg::CRS_REQ_NMI: permit_q <= irq_req_in;
            crs_pkg::CRS_REQ_HARD: permit_q <= irq_req_in & ~fltm_q;
            default: permit_q <= irq_req_in & ~fltm_q & ~prim_q &
               ((bpri_q == '0) || (irq_prio_in[BPRI_W-1:0] < bpri_q));
         endcase
      end
   end

   // core state outputs
   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         user_q <= 1'b0;
         sp_out_q <= crs_pkg::RST_WORD;
      end else begin
         user_q <= st.user;
         sp_out_q <= sp_act;
      end
   end

   assign prdata_out = prdata_q;
   assign pready_out = pready_q;
   assign pslverr_out = pslverr_q;
   assign fault_out = fault_q;
   assign irq_permit_out = permit_q;
   assign handler_mode_out = handler_q;
   assign user_level_out = user_q;
   assign stack_ptr_out = sp_out_q;
   assign pc_out = pc_q;

   // checks
   chk_sp_aligned: assert property (@(posedge clock_in) disable iff (rst_in)
      stack_ptr_out[1:0] == 2'h0) else $error("stack pointer not word aligned");
   chk_pc_aligned: assert property (@(posedge clock_in) disable iff (rst_in)
      pc_out[0] == 1'b0) else $error("program counter not half-word aligned");
   chk_link_call: assert property (@(posedge clock_in) disable iff (rst_in)
      call_in |=> link_q == $past(ret_addr_in)) else $error("return link not stored");
   chk_tbit_fault: assert property (@(posedge clock_in) disable iff (rst_in)
      setup && tbit_clr ##1 done |=> fault_out && psr_rd[24]) else $error("state bit clear");
   chk_user_fault: assert property (@(posedge clock_in) disable iff (rst_in)
      setup && st.user && is_special(paddr_in) ##1 done |=> fault_out)
      else $error("user special access did not fault");
   chk_narrow_high: assert property (@(posedge clock_in) disable iff (rst_in)
      setup && st.narrow && paddr_in == 8'h20 ##1 done |-> pslverr_out)
      else $error("narrow access reached high register");
   chk_handler_stack: assert property (@(posedge clock_in) disable iff (rst_in)
      handler_q |-> !st.alt_stack ##1 (!handler_q || mode_q[1] == 1'b0))
      else $error("alternate stack in handler mode");
   chk_prim_block: assert property (@(posedge clock_in) disable iff (rst_in)
      prim_q && $stable(prim_q) && irq_kind_in == 2'h0 |=> !irq_permit_out)
      else $error("priority mask passed an interrupt");
   chk_fltm_block: assert property (@(posedge clock_in) disable iff (rst_in)
      fltm_q && $stable(fltm_q) && irq_kind_in == 2'h1 |=> !irq_permit_out)
      else $error("fault mask passed a hard fault");
   chk_bpri_block: assert property (@(posedge clock_in) disable iff (rst_in)
      bpri_q != '0 && $stable(bpri_q) && irq_kind_in == 2'h0 &&
      irq_prio_in[BPRI_W-1:0] >= bpri_q |=> !irq_permit_out)
      else $error("base priority passed a masked interrupt");
   chk_user_level: assert property (@(posedge clock_in) disable iff (rst_in)
      mode_q[0] && !handler_q |=> user_level_out) else $error("user level not shown");
   chk_exc_view: assert property (@(posedge clock_in) disable iff (rst_in)
      exc_active_in |=> psr_rd[8:0] == $past(exc_num_in) && handler_mode_out)
      else $error("exception number not reported");

endmodule : crs_core_regs

// ==== rtl/crs_pkg.sv ====
// package: register map, field layout and reset values of the core register set
package crs_pkg;
   // apb byte offsets, one aligned word per register
   localparam logic [7:0] OFF_GPR0 = 8'h00; // numbered registers 0..15 at index*4
   localparam logic [7:0] OFF_SP = 8'h34; // active stack pointer view
   localparam logic [7:0] OFF_LINK = 8'h38; // return link
   localparam logic [7:0] OFF_PC = 8'h3c; // program counter
   localparam logic [7:0] OFF_PSR = 8'h40; // combined status, all three views
   localparam logic [7:0] OFF_APP_VIEW = 8'h44; // application view alone
   localparam logic [7:0] OFF_INT_VIEW = 8'h48; // interrupt view alone
   localparam logic [7:0] OFF_EXE_VIEW = 8'h4c; // execution view alone
   localparam logic [7:0] OFF_PRIM = 8'h50; // priority mask bit
   localparam logic [7:0] OFF_FLTM = 8'h54; // fault mask bit
   localparam logic [7:0] OFF_BPRI = 8'h58; // base priority level
   localparam logic [7:0] OFF_MODE = 8'h5c; // operating mode select
   localparam logic [7:0] OFF_MAIN_STK = 8'h60; // main stack pointer, direct
   localparam logic [7:0] OFF_PROC_STK = 8'h64; // process stack pointer, direct
   localparam logic [7:0] OFF_ACC = 8'h68; // access width control (bit0 = narrow)
   localparam logic [7:0] OFF_STAT = 8'h6c; // read-only core state
   localparam logic [7:0] OFF_LAST = 8'h6c; // highest mapped offset
   // register counts
   localparam int unsigned GPR_COUNT = 13; // general registers 0..12
   localparam logic [3:0] LOW_TOP = 4'h7; // last register every instruction reaches
   // status field layout
   localparam logic [31:0] APP_VIEW_MASK = 32'hf800_0000; // flags 31..27
   localparam logic [31:0] INT_VIEW_MASK = 32'h0000_01ff; // exception number 8..0
   localparam logic [31:0] EXE_VIEW_MASK = 32'h0700_fc00; // 26..24 and 15..10
   localparam int unsigned EXE_STATE_BIT = 24; // compact instruction state bit
   localparam int unsigned EXC_W = 9; // exception number width
   // mode select fields
   localparam int unsigned MODE_PRIV = 0; // 1 = user level in thread mode
   localparam int unsigned MODE_SPSEL = 1; // 1 = alternate stack
   // reset values
   localparam logic [31:0] RST_WORD = 32'h0000_0000;
   localparam logic [1:0] RST_MODE = 2'h0; // privileged thread, main stack
   localparam logic [31:0] RST_FLAGS = 32'h0100_0000; // only the state bit set
   // request kinds seen by the mask logic
   typedef enum logic [1:0] {
      CRS_REQ_IRQ = 2'h0,
      CRS_REQ_HARD = 2'h1,
      CRS_REQ_NMI = 2'h3
   } crs_req_e;
   // decoded core state carried as one group
   typedef struct packed {
      logic handler; // servicing an exception
      logic user; // unprivileged thread
      logic alt_stack; // process stack active
      logic narrow; // accesses behave as 16-bit instructions
   } crs_state_s;
endpackage : crs_pkg

// ==== sim/test_cpu_core_register_set.sv ====
// self-checking apb bench for the core register set
`timescale 1ns/1ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin num_errors++; \
   $display("BAD %0t got %h exp %h", $time, (g), (e)); end end

module test_cpu_core_register_set;
   logic clock_in = 1'b0; // 200 mhz core clock
   logic rst_in = 1'b1; // async reset, held at start
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0; // apb request
   logic [7:0] paddr = 8'h00; // apb byte address
   logic [31:0] pwdata = 32'h0000_0000, prdata; // apb data
   logic pready, pslverr; // apb answer
   logic exc_active = 1'b0, call = 1'b0, irq_req = 1'b0; // core events
   logic [8:0] exc_num = 9'h000, irq_prio = 9'h000; // exception and priority
   logic [31:0] ret_addr = 32'h0000_0000; // call return address
   logic [1:0] irq_kind = 2'h0; // request kind
   logic permit, fault, handler, user; // core state outputs
   logic [31:0] sp, pc; // aligned pointers
   int num_errors = 0, n_tests = 0, cycles = 0; // verdict counters
   logic [31:0] rdata; // data of last transfer
   logic serr; // error of last transfer

   // clock: half period 2.5 ns
   always #2.5 clock_in = ~clock_in;

   crs_core_regs DUT (.clock_in(clock_in), .rst_in(rst_in), .psel_in(psel),
      .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
      .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
      .exc_active_in(exc_active), .exc_num_in(exc_num), .call_in(call),
      .ret_addr_in(ret_addr), .irq_req_in(irq_req), .irq_kind_in(irq_kind),
      .irq_prio_in(irq_prio), .irq_permit_out(permit), .fault_out(fault),
      .handler_mode_out(handler), .user_level_out(user), .stack_ptr_out(sp), .pc_out(pc));

   // verdict and end of run
   task automatic wrap_up();
      if (num_errors == 0 && n_tests > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : wrap_up

   // hang guard, run needs well under a thousand cycles
   always @(posedge clock_in) begin
      cycles++;
      if (cycles == 3000) begin
         num_errors++;
         $display("BAD %0t timeout", $time);
         wrap_up();
      end
   end

   // one apb transfer; idle edge first so no signal is assigned twice in a step
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clock_in);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock_in);
      penable <= 1'b1;
      @(posedge clock_in);
      while (pready !== 1'b1) @(posedge clock_in); // wait stays open, guard ends a hang
      rdata = prdata;
      serr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : xfer

   // write with expected error flag
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic e);
      xfer(1'b1, a, d);
      `CHK(serr, e)
   endtask : wr

   // read with expected data and error flag
   task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic e);
      xfer(1'b0, a, 32'h0000_0000);
      `CHK(serr, e)
      `CHK(rdata, x)
   endtask : rd

   // one request sample, permit appears one cycle after the sampling edge
   task automatic mask(input logic [1:0] k, input logic [8:0] p, input logic x);
      @(posedge clock_in);
      irq_req <= 1'b1;
      irq_kind <= k;
      irq_prio <= p;
      @(posedge clock_in);
      irq_req <= 1'b0;
      @(posedge clock_in);
      `CHK(permit, x)
   endtask : mask

   // main sequence
   initial begin
      repeat (6) @(posedge clock_in);
      rst_in <= 1'b0;
      rd(crs_pkg::OFF_MODE, 32'h0, 1'b0);
      rd(crs_pkg::OFF_BPRI, 32'h0, 1'b0);
      rd(crs_pkg::OFF_EXE_VIEW, 32'h0100_0000, 1'b0);
      // first and last general register, then an unmapped word
      wr(8'h00, 32'ha5a5_0001, 1'b0);
      wr(8'h30, 32'h5a5a_000c, 1'b0);
      rd(8'h00, 32'ha5a5_0001, 1'b0);
      rd(8'h30, 32'h5a5a_000c, 1'b0);
      wr(8'h70, 32'hffff_ffff, 1'b1);
      // narrow accesses stop at register 7
      wr(crs_pkg::OFF_ACC, 32'h1, 1'b0);
      rd(8'h1c, 32'h0, 1'b0);
      rd(8'h20, 32'h0, 1'b1);
      wr(crs_pkg::OFF_ACC, 32'h0, 1'b0);
      // odd program counter and unaligned stack pointer
      wr(crs_pkg::OFF_PC, 32'h0000_1235, 1'b0);
      rd(crs_pkg::OFF_PC, 32'h0000_1234, 1'b0);
      `CHK(pc, 32'h0000_1234)
      wr(crs_pkg::OFF_SP, 32'h2000_0ffb, 1'b0);
      rd(crs_pkg::OFF_SP, 32'h2000_0ff8, 1'b0);
      `CHK(sp, 32'h2000_0ff8)
      // alternate stack in thread mode lands in the process pointer
      wr(crs_pkg::OFF_MODE, 32'h2, 1'b0);
      wr(crs_pkg::OFF_SP, 32'h3000_0100, 1'b0);
      rd(crs_pkg::OFF_PROC_STK, 32'h3000_0100, 1'b0);
      `CHK(sp, 32'h3000_0100)
      // status views, then an attempt to clear the state bit
      wr(crs_pkg::OFF_PSR, 32'hffff_ffff, 1'b0);
      rd(crs_pkg::OFF_APP_VIEW, 32'hf800_0000, 1'b0);
      rd(crs_pkg::OFF_EXE_VIEW, 32'h0700_fc00, 1'b0);
      rd(crs_pkg::OFF_PSR, 32'hff00_fc00, 1'b0);
      wr(crs_pkg::OFF_EXE_VIEW, 32'h0, 1'b1);
      @(posedge clock_in);
      `CHK(fault, 1'b1)
      rd(crs_pkg::OFF_EXE_VIEW, 32'h0700_fc00, 1'b0);
      // subroutine call
      @(posedge clock_in);
      call <= 1'b1; ret_addr <= 32'h0000_4a11;
      @(posedge clock_in);
      call <= 1'b0;
      rd(crs_pkg::OFF_LINK, 32'h0000_4a11, 1'b0);
      // masking of the three request kinds
      mask(crs_pkg::CRS_REQ_IRQ, 9'h010, 1'b1);
      wr(crs_pkg::OFF_PRIM, 32'h1, 1'b0);
      mask(crs_pkg::CRS_REQ_IRQ, 9'h010, 1'b0);
      mask(2'h2, 9'h010, 1'b0);
      mask(crs_pkg::CRS_REQ_HARD, 9'h010, 1'b1);
      wr(crs_pkg::OFF_PRIM, 32'h0, 1'b0);
      wr(crs_pkg::OFF_FLTM, 32'h1, 1'b0);
      mask(crs_pkg::CRS_REQ_HARD, 9'h010, 1'b0);
      mask(crs_pkg::CRS_REQ_NMI, 9'h010, 1'b1);
      wr(crs_pkg::OFF_FLTM, 32'h0, 1'b0);
      wr(crs_pkg::OFF_BPRI, 32'h4, 1'b0);
      mask(crs_pkg::CRS_REQ_IRQ, 9'h004, 1'b0);
      mask(crs_pkg::CRS_REQ_IRQ, 9'h003, 1'b1);
      wr(crs_pkg::OFF_BPRI, 32'h0, 1'b0);
      // handler mode drops the alternate stack
      @(posedge clock_in);
      exc_active <= 1'b1; exc_num <= 9'h1a5;
      repeat (2) @(posedge clock_in);
      `CHK(handler, 1'b1)
      rd(crs_pkg::OFF_INT_VIEW, 32'h0000_01a5, 1'b0);
      rd(crs_pkg::OFF_MODE, 32'h0, 1'b0);
      `CHK(sp, 32'h2000_0ff8)
      exc_active <= 1'b0;
      // user level thread, special access refused
      wr(crs_pkg::OFF_MODE, 32'h1, 1'b0);
      repeat (2) @(posedge clock_in);
      `CHK(user, 1'b1)
      wr(crs_pkg::OFF_PRIM, 32'h1, 1'b1);
      @(posedge clock_in);
      `CHK(fault, 1'b1)
      exc_active <= 1'b1;
      // handler mode one edge, user flag one more, then looked at
      repeat (3) @(posedge clock_in);
      `CHK(user, 1'b0)
      rd(crs_pkg::OFF_STAT, 32'h0000_0001, 1'b0);
      wr(crs_pkg::OFF_MODE, 32'h0, 1'b0);
      rd(crs_pkg::OFF_PRIM, 32'h0, 1'b0);
      wrap_up();
   end
endmodule : test_cpu_core_register_set
